/* File: rtl/ppr_defines.svh */
// constants for the port pad block: widths, pin indices, reset-pin timing
`ifndef PPR_DEFINES_SVH
`define PPR_DEFINES_SVH

`define PPR_NPINS         27
`define PPR_PORTB_LSB     0
`define PPR_PORTC_LSB     8
`define PPR_PORTD_LSB     16
`define PPR_PORTE_LSB     24
`define PPR_PIN_E0        24
`define PPR_PIN_E1        25
`define PPR_PIN_E2        26
`define PPR_SYS_CLK_NS    40
`define PPR_RST_MIN_NS    2500
`define PPR_RST_MIN_CYC   ((`PPR_RST_MIN_NS + `PPR_SYS_CLK_NS - 1) / `PPR_SYS_CLK_NS)
`define PPR_CNT_W         8

`endif

/* File: rtl/ppr_pkg.sv */
// types shared by the port pad block
`include "ppr_defines.svh"
package ppr_pkg;
    // per-pin software settings, index = pin-change source number
    typedef struct packed {
        logic [`PPR_NPINS-1:0] out_val;  // output value
        logic [`PPR_NPINS-1:0] dir;      // 1 = output
        logic [`PPR_NPINS-1:0] pull_en;  // pull-up enable
    } ppr_ctl_s;
    // what the pad ring is told to do
    typedef struct packed {
        logic [`PPR_NPINS-1:0] out_val;  // driven level
        logic [`PPR_NPINS-1:0] oe;       // 1 = driving
        logic [`PPR_NPINS-1:0] pull;     // pull-up on
    } ppr_pad_s;
    // reset-pin filter states
    typedef enum logic [1:0] {
        RF_IDLE  = 2'b00,
        RF_COUNT = 2'b01,
        RF_HOLD  = 2'b10
    } ppr_rf_e;
endpackage : ppr_pkg

/* File: rtl/ppr_port_pads.sv */
// pad control for ports b, c, d, e with reset pin and crystal pin selection
`timescale 1ns/1ps
`include "ppr_defines.svh"

// What this block does
// - ports b, c, d: 8 pins, own pull-ups
// - port e: 3 pins, own pull-ups
// - any reset tri-states every pin
// - fuse programmed: e0 is plain i/o
// - fuse unprogrammed: e0 is reset input
// - low beyond minimum pulse makes a reset
// - crystal mode: e1 feeds oscillator amplifier
// - crystal mode: e2 is amplifier output
// - each pin has numbered pin-change source
module ppr_port_pads (
    // clock and reset
    input  wire logic                    sys_clk,
    input  wire logic                    sys_rst,
    // software settings, same cycle domain
    input  wire ppr_pkg::ppr_ctl_s       ctl_i,
    // fuses: 1 = programmed / crystal selected
    input  wire logic                    reset_pin_disable_fuse,
    input  wire logic                    crystal_sel_fuse,
    // pin levels from the pads, asynchronous
    input  wire logic [`PPR_NPINS-1:0]   pad_in,
    // pad drive
    output ppr_pkg::ppr_pad_s            pad_r,
    // synchronised pin levels and change pulses
    output logic [`PPR_NPINS-1:0]        pin_state_r,
    output logic [`PPR_NPINS-1:0]        pin_change_r,
    // reset request from e0 and oscillator input
    output logic                         ext_reset_req_r,
    output logic                         crystal_amp_input_r
);
    import ppr_pkg::*;

    localparam int MIN_CYC = `PPR_RST_MIN_CYC;  // least low time in cycles

    logic [`PPR_NPINS-1:0] sync1_r;         // first stage, read only by sync2
    logic [`PPR_NPINS-1:0] sync2_r;         // safe pin levels
    logic [`PPR_NPINS-1:0] prev_r;          // last cycle's levels
    logic [`PPR_NPINS-1:0] prev_nxt;
    logic [`PPR_NPINS-1:0] sync1_nxt;
    logic [`PPR_NPINS-1:0] sync2_nxt;
    logic [`PPR_NPINS-1:0] change_nxt;
    logic                  prime_r;         // first cycle after reset, edges masked
    logic                  prime_nxt;
    ppr_rf_e               rf_state_r;      // reset-pin filter state
    ppr_rf_e               rf_state_nxt;
    logic [`PPR_CNT_W-1:0] rf_cnt_r;        // cycles seen low
    logic [`PPR_CNT_W-1:0] rf_cnt_nxt;
    logic                  ext_rst_nxt;
    logic                  xin_nxt;
    ppr_pad_s              pad_nxt;
    logic                  in_reset;        // any reset source active

    // true when a fuse-selected function owns the pin
    function automatic logic special_owned(input int idx, input logic rst_dis,
                                           input logic xtal);
        special_owned = ((idx == `PPR_PIN_E0) && !rst_dis) ||
                        ((idx == `PPR_PIN_E1 || idx == `PPR_PIN_E2) && xtal);
    endfunction : special_owned

    // two-flop synchroniser; change detect reads only the second stage
    // the pipe is not cleared by reset: a zero there would fake an edge on
    // every pin idling high; prime_r masks the one compare after release
    always_comb begin
        prime_nxt  = sys_rst;
        sync1_nxt  = pad_in;
        sync2_nxt  = sync1_r;
        prev_nxt   = sync2_r;
        change_nxt = (sys_rst || prime_r) ? '0 : (sync2_r ^ prev_r);  // source n
    end

    always_ff @(posedge sys_clk) begin
        prime_r      <= prime_nxt;
        sync1_r      <= sync1_nxt;
        sync2_r      <= sync2_nxt;
        prev_r       <= prev_nxt;
        pin_change_r <= change_nxt;
    end

    assign pin_state_r = prev_r;  // flop output, one cycle behind sync2

    // reset-pin low filter; short glitches never reach hold
    always_comb begin
        rf_state_nxt = rf_state_r;
        rf_cnt_nxt   = rf_cnt_r;
        unique case (rf_state_r)
            RF_IDLE: begin
                // fuse programmed: pin is gpio, filter stays asleep
                if (!reset_pin_disable_fuse && !sync2_r[`PPR_PIN_E0]) begin
                    rf_state_nxt = RF_COUNT;
                    rf_cnt_nxt   = `PPR_CNT_W'(1);
                end
            end
            RF_COUNT: begin
                if (reset_pin_disable_fuse || sync2_r[`PPR_PIN_E0]) begin
                    rf_state_nxt = RF_IDLE;  // pulse too short
                    rf_cnt_nxt   = '0;
                end else if (rf_cnt_r >= `PPR_CNT_W'(MIN_CYC)) begin
                    rf_state_nxt = RF_HOLD;
                end else begin
                    rf_cnt_nxt = rf_cnt_r + `PPR_CNT_W'(1);
                end
            end
            RF_HOLD: begin
                // reset lasts while the pin stays low
                if (reset_pin_disable_fuse || sync2_r[`PPR_PIN_E0]) begin
                    rf_state_nxt = RF_IDLE;
                    rf_cnt_nxt   = '0;
                end
            end
            default: begin
                rf_state_nxt = RF_IDLE;  // illegal code recovers
                rf_cnt_nxt   = '0;
            end
        endcase
        ext_rst_nxt = (rf_state_nxt == RF_HOLD);
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rf_state_r      <= RF_IDLE;
            rf_cnt_r        <= '0;
            ext_reset_req_r <= 1'b0;
        end else begin
            rf_state_r      <= rf_state_nxt;
            rf_cnt_r        <= rf_cnt_nxt;
            ext_reset_req_r <= ext_rst_nxt;
        end
    end

    // pin-held reset tri-states the pads as the system reset does
    assign in_reset = sys_rst || (rf_state_r == RF_HOLD);

    // pad drive per pin; pull-ups off in reset so the pins truly float
    always_comb begin
        pad_nxt = '0;
        xin_nxt = (crystal_sel_fuse && !sys_rst) ? sync2_r[`PPR_PIN_E1] : 1'b0;
        for (int i = 0; i < `PPR_NPINS; i++) begin
            if (in_reset) begin
                pad_nxt.oe[i] = 1'b0;
            end else if (special_owned(i, reset_pin_disable_fuse, crystal_sel_fuse)) begin
                // owned pins are inputs; e2 drives the inverted e1 level
                if (i == `PPR_PIN_E2) begin
                    pad_nxt.oe[i]      = 1'b1;
                    pad_nxt.out_val[i] = !sync2_r[`PPR_PIN_E1];
                end else begin
                    pad_nxt.pull[i] = ctl_i.pull_en[i];
                end
            end else begin
                pad_nxt.oe[i]      = ctl_i.dir[i];
                pad_nxt.out_val[i] = ctl_i.out_val[i];
                pad_nxt.pull[i]    = !ctl_i.dir[i] && ctl_i.pull_en[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        pad_r               <= pad_nxt;  // sys_rst clears via in_reset
        crystal_amp_input_r <= xin_nxt;  // reset folded into xin_nxt
    end

    // ---------------- checks ----------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    logic [`PPR_NPINS-1:0] norm_mask;  // pins no special function owns
    logic [`PPR_CNT_W-1:0] low_run_r;  // consecutive low e0 samples
    always_comb begin
        for (int i = 0; i < `PPR_NPINS; i++) begin
            norm_mask[i] = !special_owned(i, reset_pin_disable_fuse, crystal_sel_fuse);
        end
    end
    always_ff @(posedge sys_clk) begin
        if (sys_rst || reset_pin_disable_fuse || sync2_r[`PPR_PIN_E0]) begin
            low_run_r <= '0;
        end else if (low_run_r != '1) begin
            low_run_r <= low_run_r + `PPR_CNT_W'(1);
        end
    end

    sequence enter_hold_s;
        (rf_state_r == RF_COUNT) ##1 (rf_state_r == RF_HOLD);
    endsequence
    sequence long_low_s;
        (low_run_r > `PPR_CNT_W'(MIN_CYC + 1)) && !reset_pin_disable_fuse;
    endsequence

    reset_tristate_a: assert property (disable iff (1'b0) sys_rst |=> pad_r.oe == '0)
        else $error("pads driven after reset");
    pull_bcd_a: assert property (!in_reset |=>
            pad_r.pull[23:0] == (~$past(ctl_i.dir[23:0]) & $past(ctl_i.pull_en[23:0])))
        else $error("port b/c/d pull-up wrong");
    pull_e_a: assert property (!in_reset && !crystal_sel_fuse |=>
            pad_r.pull[26:25] == (~$past(ctl_i.dir[26:25]) & $past(ctl_i.pull_en[26:25])))
        else $error("port e pull-up wrong");
    e0_gpio_a: assert property (reset_pin_disable_fuse && !in_reset |=>
            pad_r.oe[24] == $past(ctl_i.dir[24]) && !ext_reset_req_r)
        else $error("e0 not plain i/o");
    e0_input_a: assert property (!reset_pin_disable_fuse |=> !pad_r.oe[24])
        else $error("reset pin driven");
    pin_reset_a: assert property (enter_hold_s |-> low_run_r >= `PPR_CNT_W'(MIN_CYC))
        else $error("reset from short pulse");
    long_low_a: assert property (long_low_s |-> ext_reset_req_r)
        else $error("long low pulse ignored");
    xtal_in_a: assert property (crystal_sel_fuse |=>
            !pad_r.oe[25] && crystal_amp_input_r == $past(sync2_r[25]))
        else $error("crystal input misrouted");
    xtal_out_a: assert property (crystal_sel_fuse && !in_reset |=>
            pad_r.oe[26] && pad_r.out_val[26] == !$past(sync2_r[25]))
        else $error("crystal output misrouted");
    pc_e0_a: assert property ($changed(sync2_r[24]) && !prime_r |=> pin_change_r[24])
        else $error("e0 change not on source 24");
    gpio_drive_a: assert property (!in_reset |=>
            (pad_r.oe & $past(norm_mask)) == ($past(ctl_i.dir) & $past(norm_mask)))
        else $error("gpio direction not followed");
endmodule : ppr_port_pads

/* File: test/ppr_board.sv */
// board-side model of the pins: block drive, board drivers, pull-ups, floating lines
`timescale 1ns/1ps
`include "ppr_defines.svh"
module ppr_board (
    // clock
    input  wire logic                  sys_clk,
    // pad drive from the block
    input  wire ppr_pkg::ppr_pad_s     pad_r,
    // board drivers
    input  wire logic [`PPR_NPINS-1:0] ext_en,
    input  wire logic [`PPR_NPINS-1:0] ext_val,
    // resolved pin levels
    output logic      [`PPR_NPINS-1:0] pad_in
);
    import ppr_pkg::*;
    logic [`PPR_NPINS-1:0] last_r; // last level, so a floating line never holds
    // remember the level every cycle
    always @(posedge sys_clk) last_r <= pad_in;
    // pad first, then board, then pull-up; a floating line wanders
    always_comb begin
        for (int i = 0; i < `PPR_NPINS; i++) begin
            pad_in[i] = pad_r.oe[i] ? pad_r.out_val[i] : ext_en[i] ? ext_val[i]
                      : pad_r.pull[i] ? 1'b1 : ~last_r[i];
        end
    end
endmodule : ppr_board

/* File: test/tb.sv */
// self-checking bench for the port pad block
`timescale 1ns/1ps
`include "ppr_defines.svh"
module tb;
    import ppr_pkg::*;
    // all outputs in one word
    typedef struct packed {
        logic                  req;
        logic                  amp;
        logic [`PPR_NPINS-1:0] chg;
        logic [`PPR_NPINS-1:0] st;
        ppr_pad_s              pad;
    } ppr_obs_s;
    typedef struct {string nm; ppr_obs_s e; ppr_obs_s m;} ppr_note_s;
    logic                  sys_clk  = 1'b0;
    logic                  sys_rst  = 1'b1;
    ppr_ctl_s              ctl_i    = '0;
    logic                  rdf      = 1'b0; // reset pin disable fuse
    logic                  xsel     = 1'b0; // crystal select fuse
    logic [`PPR_NPINS-1:0] ext_en   = '1;   // board drives every pin
    logic [`PPR_NPINS-1:0] ext_val  = '1;
    logic [`PPR_NPINS-1:0] pad_in;
    ppr_obs_s              o;
    ppr_note_s             q[$];    // expected results, oldest first
    event                  ev;
    int                    fails    = 0;
    int                    n_checks = 0;
    int                    seed     = 32'h9ec9ddda;
    ppr_port_pads DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .ctl_i(ctl_i),
        .reset_pin_disable_fuse(rdf), .crystal_sel_fuse(xsel), .pad_in(pad_in),
        .pad_r(o.pad), .pin_state_r(o.st), .pin_change_r(o.chg),
        .ext_reset_req_r(o.req), .crystal_amp_input_r(o.amp));
    ppr_board brd (.sys_clk(sys_clk), .pad_r(o.pad), .ext_en(ext_en),
        .ext_val(ext_val), .pad_in(pad_in));
    // 25 mhz clock
    always #20 sys_clk = ~sys_clk;
    // verdict and end of run
    task automatic stop_test();
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    // note a result; the watcher compares at once, outputs are settled at negedge
    task automatic expect_obs(string nm, ppr_obs_s e, ppr_obs_s m);
        q.push_back('{nm, e, m});
        -> ev;
    endtask : expect_obs
    task automatic cmp(ppr_note_s n);
        n_checks++;
        if ((o & n.m) !== (n.e & n.m)) begin
            fails++;
            $display("BAD %s exp %h seen %h", n.nm, n.e & n.m, o & n.m);
        end
    endtask : cmp
    // watcher: oldest note against the outputs
    initial forever begin
        @(ev);
        while (q.size() > 0) cmp(q.pop_front());
    end
    task automatic cyc(int k);
        repeat (k) @(negedge sys_clk);
    endtask : cyc
    // expected pad drive; pins owned by a fuse ignore dir and out_val
    function automatic void pad_exp(output ppr_obs_s e, output ppr_obs_s m);
        logic [`PPR_NPINS-1:0] own;
        own = '0;
        own[`PPR_PIN_E0] = !rdf;
        own[`PPR_PIN_E1] = xsel;
        own[`PPR_PIN_E2] = xsel;
        e = '0;
        m = '0;
        e.pad.oe = ctl_i.dir & ~own;
        e.pad.oe[`PPR_PIN_E2] = e.pad.oe[`PPR_PIN_E2] | xsel;
        e.pad.pull = ctl_i.pull_en & ~e.pad.oe;
        e.pad.out_val = ctl_i.out_val;
        m.pad.oe = '1;
        m.pad.pull = '1;
        m.pad.out_val = e.pad.oe & ~own;
    endfunction : pad_exp
    // watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #(40 * 3000);
        fails++;
        stop_test();
    end
    // main sequence
    initial begin
        ppr_obs_s e;
        ppr_obs_s m;
        int       i;
        cyc(3);
        e = '0;
        m = '0;
        m.pad = '1;
        expect_obs("pads in reset", e, m);
        sys_rst = 1'b0;
        // random settings over every fuse combination
        for (int k = 0; k < 12; k++) begin
            {rdf, xsel} = k[1:0];
            ctl_i.out_val = `PPR_NPINS'($random(seed));
            ctl_i.dir     = `PPR_NPINS'($random(seed));
            ctl_i.pull_en = `PPR_NPINS'($random(seed));
            ext_val       = `PPR_NPINS'($random(seed));
            ext_val[`PPR_PIN_E0] = 1'b1;
            cyc(1);
            pad_exp(e, m);
            expect_obs("pad drive", e, m);
        end
        // crystal mode: e1 feeds the amplifier, e2 drives its inverse
        ctl_i = '0;
        for (int v = 0; v < 2; v++) begin
            ext_val[`PPR_PIN_E1] = v[0];
            cyc(4);
            e = '0;
            m = '0;
            e.amp = v[0];
            e.pad.out_val[`PPR_PIN_E2] = ~v[0];
            m.amp = 1'b1;
            m.pad.out_val[`PPR_PIN_E2] = 1'b1;
            expect_obs("crystal", e, m);
        end
        // pin change pulses, e0 and e2 included, 3 edges after the pin moves
        {rdf, xsel} = 2'b10;
        ext_val = '1;
        cyc(4);
        for (int k = 0; k < 8; k++) begin
            i = (k < 2) ? `PPR_PIN_E0 + 2 * k : {$random(seed)} % `PPR_NPINS;
            ext_val[i] = ~ext_val[i];
            cyc(3);
            e = '0;
            m = '0;
            m.chg = '1;
            m.st[i] = 1'b1;
            e.chg[i] = 1'b1;
            e.st[i] = ext_val[i];
            expect_obs("change pulse", e, m);
            cyc(1);
            e.chg = '0;
            expect_obs("pulse end", e, m);
        end
        // reset pin: short low ignored, long low resets and tri-states
        ctl_i.dir = '1;
        for (int f = 1; f >= 0; f--) begin
            rdf = f[0];
            ext_val[`PPR_PIN_E0] = 1'b0;
            cyc(10);
            ext_val[`PPR_PIN_E0] = 1'b1;
            cyc(8);
            pad_exp(e, m);
            m.req = 1'b1;
            expect_obs("short low", e, m);
            ext_val[`PPR_PIN_E0] = 1'b0; // held past the minimum
            cyc(`PPR_RST_MIN_CYC + 8);
            if (f == 0) begin
                e.req = 1'b1;
                e.pad = '0;
            end
            expect_obs("long low", e, m);
            ext_val[`PPR_PIN_E0] = 1'b1;
            cyc(8);
            pad_exp(e, m);
            m.req = 1'b1;
            expect_obs("reset pin freed", e, m);
        end
        stop_test();
    end
endmodule : tb
